// File: hw/ldo_regulator_control_regs.sv
// Regulator control register bank behind the control slave register port.
`timescale 1ns/1ps
`include "ldo_regs_consts.svh"

module ldo_regulator_control_regs
   import ldo_regs_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rstn_i,
   input  wire logic       warm_rst_i,
   // Register port from the control slave
   input  reg_req_s        req_i,
   output logic      [7:0] rdata_o,
   output logic            rvalid_o,
   // System context
   input  sys_state_e      sys_state_i,
   input  wire logic       d_group_on_i,
   input  wire logic       c_group_on_i,
   input  wire logic [5:0] b_nvm_voltage_select_code_i,
   input  wire logic [5:0] d_nvm_voltage_select_code_i,
   input  wire logic [5:0] c_nvm_voltage_select_code_i,
   input  wire logic [5:0] f_nvm_voltage_select_code_i,
   // Regulator controls
   output ldo_state_e      b_state_o,
   output ldo_state_e      d_state_o,
   output ldo_state_e      c_state_o,
   output ldo_state_e      f_state_o,
   output ldo_cmd_e        d_cmd_o,
   output ldo_cmd_e        c_cmd_o,
   output ldo_cmd_e        f_cmd_o,
   output ldo_cmd_e        ln_cmd_o,
   output logic      [5:0] b_voltage_select_code_o,
   output logic      [5:0] d_voltage_select_code_o,
   output logic      [5:0] c_voltage_select_code_o,
   output logic      [5:0] f_voltage_select_code_o
);

   ////////////////////////////////////////////////////////////////////////
   // Reset release through two flip-flops, then a one-cycle default load.
   logic rst_meta_q;
   logic rst_sync_q;
   logic load_q;
   wire  rstn = rst_sync_q;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   always_ff @(posedge clk_i or negedge rstn) begin
      if (!rstn) begin
         load_q <= 1'b1;
      end else begin
         load_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Decode helpers.
   function automatic ldo_state_e decode_state(input logic [1:0] code);
      ldo_state_e s;
      s = REQ_OFF;
      if (code == 2'b01) begin
         s = REQ_ON;
      end else if (code == 2'b11) begin
         s = REQ_SLEEP;
      end
      return s;
   endfunction : decode_state

   function automatic ldo_cmd_e pick_cmd(input logic [1:0] off_c,
                                         input logic [1:0] slp_c,
                                         input logic [1:0] act_c,
                                         input sys_state_e st);
      logic [1:0] c;
      c = off_c;
      if (st == SYS_SLEEP) begin
         c = slp_c;
      end else if (st == SYS_ACTIVE) begin
         c = act_c;
      end
      return ldo_cmd_e'(c);
   endfunction : pick_cmd

   function automatic logic [7:0] trans_word(input logic slp_lo,
                                             input logic act_hi);
      return {2'b00, `OFF_CMD_RST, 1'b0, slp_lo, act_hi, 1'b1};
   endfunction : trans_word

   ////////////////////////////////////////////////////////////////////////
   // Address decode.
   wire wr = req_i.wr;
   wire [7:0] a = req_i.addr;
   wire [7:0] wd = req_i.wdata;
   wire wr_b_st = wr && (a == `OFS_LDO_B_STATE);
   wire wr_b_v  = wr && (a == `OFS_LDO_B_VOLTAGE);
   wire wr_d_tr = wr && (a == `OFS_LDO_D_TRANSITION_CMD);
   wire wr_d_st = wr && (a == `OFS_LDO_D_STATE);
   wire wr_d_v  = wr && (a == `OFS_LDO_D_VOLTAGE);
   wire wr_c_tr = wr && (a == `OFS_LDO_C_TRANSITION_CMD);
   wire wr_c_st = wr && (a == `OFS_LDO_C_STATE);
   wire wr_c_v  = wr && (a == `OFS_LDO_C_VOLTAGE);
   wire wr_f_tr = wr && (a == `OFS_LDO_F_TRANSITION_CMD);
   wire wr_f_st = wr && (a == `OFS_LDO_F_STATE);
   wire wr_f_v  = wr && (a == `OFS_LDO_F_VOLTAGE);
   wire wr_l_tr = wr && (a == `OFS_LOW_NOISE_TRANSITION_CMD);

   ////////////////////////////////////////////////////////////////////////
   // State fields: state domain, untouched by a warm reset.
   logic [1:0] b_st_q;
   logic [1:0] d_st_q;
   logic [1:0] c_st_q;
   logic [1:0] f_st_q;

   always_ff @(posedge clk_i or negedge rstn) begin
      if (!rstn) begin
         b_st_q <= `STATE_RST;
         d_st_q <= `STATE_RST;
         c_st_q <= `STATE_RST;
         f_st_q <= `STATE_RST;
      end else begin
         b_st_q <= wr_b_st ? wd[1:0] : b_st_q;
         d_st_q <= wr_d_st ? wd[1:0] : d_st_q;
         c_st_q <= wr_c_st ? wd[1:0] : c_st_q;
         f_st_q <= wr_f_st ? wd[1:0] : f_st_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transition commands: config domain, set back to their reset values by a warm reset too.
   // Index 0..3 holds regulators d, c, f and low noise.
   logic [3:0] slp_lo_q;
   logic [3:0] act_hi_q;
   wire  [3:0] tr_wr = {wr_l_tr, wr_f_tr, wr_c_tr, wr_d_tr};

   always_ff @(posedge clk_i or negedge rstn) begin
      if (!rstn) begin
         slp_lo_q <= {4{`SLEEP_CMD_LO_RST}};
         act_hi_q <= {4{`ACT_CMD_HI_RST}};
      end else if (warm_rst_i) begin
         slp_lo_q <= {4{`SLEEP_CMD_LO_RST}};
         act_hi_q <= {4{`ACT_CMD_HI_RST}};
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (tr_wr[i]) begin
               slp_lo_q[i] <= wd[`POS_SLEEP_CMD];
               act_hi_q[i] <= wd[`POS_ACT_CMD + 1];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Voltage registers.
   logic [7:0] b_v_rd;
   logic [7:0] d_v_rd;
   logic [7:0] c_v_rd;
   logic [7:0] f_v_rd;

   ldo_voltage_reg #(.TOP_BIT_WRITABLE(1'b1)) u_b_volt (
      .clk_i(clk_i), .rstn_i(rstn), .load_default_i(load_q),
      .warm_rst_i(warm_rst_i), .wr_i(wr_b_v), .wdata_i(wd),
      .nvm_default_i(b_nvm_voltage_select_code_i), .rdata_o(b_v_rd),
      .voltage_select_code_o(b_voltage_select_code_o));
   ldo_voltage_reg #(.TOP_BIT_WRITABLE(1'b0)) u_d_volt (
      .clk_i(clk_i), .rstn_i(rstn), .load_default_i(load_q),
      .warm_rst_i(warm_rst_i), .wr_i(wr_d_v), .wdata_i(wd),
      .nvm_default_i(d_nvm_voltage_select_code_i), .rdata_o(d_v_rd),
      .voltage_select_code_o(d_voltage_select_code_o));
   ldo_voltage_reg #(.TOP_BIT_WRITABLE(1'b0)) u_c_volt (
      .clk_i(clk_i), .rstn_i(rstn), .load_default_i(load_q),
      .warm_rst_i(warm_rst_i), .wr_i(wr_c_v), .wdata_i(wd),
      .nvm_default_i(c_nvm_voltage_select_code_i), .rdata_o(c_v_rd),
      .voltage_select_code_o(c_voltage_select_code_o));
   ldo_voltage_reg #(.TOP_BIT_WRITABLE(1'b0)) u_f_volt (
      .clk_i(clk_i), .rstn_i(rstn), .load_default_i(load_q),
      .warm_rst_i(warm_rst_i), .wr_i(wr_f_v), .wdata_i(wd),
      .nvm_default_i(f_nvm_voltage_select_code_i), .rdata_o(f_v_rd),
      .voltage_select_code_o(f_voltage_select_code_o));

   ////////////////////////////////////////////////////////////////////////
   // Read multiplexer; unmapped addresses read zero.
   logic [7:0] rd_mux;

   always_comb begin
      rd_mux = 8'h00;
      if (a == `OFS_LDO_B_STATE) begin
         rd_mux = {6'h00, b_st_q};
      end else if (a == `OFS_LDO_B_VOLTAGE) begin
         rd_mux = b_v_rd;
      end else if (a == `OFS_LDO_D_TRANSITION_CMD) begin
         rd_mux = trans_word(slp_lo_q[0], act_hi_q[0]);
      end else if (a == `OFS_LDO_D_STATE) begin
         rd_mux = {6'h00, d_st_q};
      end else if (a == `OFS_LDO_D_VOLTAGE) begin
         rd_mux = d_v_rd;
      end else if (a == `OFS_LDO_C_TRANSITION_CMD) begin
         rd_mux = trans_word(slp_lo_q[1], act_hi_q[1]);
      end else if (a == `OFS_LDO_C_STATE) begin
         rd_mux = {6'h00, c_st_q};
      end else if (a == `OFS_LDO_C_VOLTAGE) begin
         rd_mux = c_v_rd;
      end else if (a == `OFS_LDO_F_TRANSITION_CMD) begin
         rd_mux = trans_word(slp_lo_q[2], act_hi_q[2]);
      end else if (a == `OFS_LDO_F_STATE) begin
         rd_mux = {6'h00, f_st_q};
      end else if (a == `OFS_LDO_F_VOLTAGE) begin
         rd_mux = f_v_rd;
      end else if (a == `OFS_LOW_NOISE_TRANSITION_CMD) begin
         rd_mux = trans_word(slp_lo_q[3], act_hi_q[3]);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registered answers and regulator controls.
   wire [1:0] off_c = `OFF_CMD_RST;
   wire ldo_state_e d_dec = decode_state(d_st_q);
   wire ldo_state_e c_dec = decode_state(c_st_q);

   always_ff @(posedge clk_i or negedge rstn) begin
      if (!rstn) begin
         rdata_o   <= 8'h00;
         rvalid_o  <= 1'b0;
         b_state_o <= REQ_OFF;
         d_state_o <= REQ_OFF;
         c_state_o <= REQ_OFF;
         f_state_o <= REQ_OFF;
         d_cmd_o   <= CMD_OFF;
         c_cmd_o   <= CMD_OFF;
         f_cmd_o   <= CMD_OFF;
         ln_cmd_o  <= CMD_OFF;
      end else begin
         rdata_o   <= req_i.rd ? rd_mux : rdata_o;
         rvalid_o  <= req_i.rd;
         b_state_o <= decode_state(b_st_q);
         d_state_o <= d_group_on_i ? d_dec : REQ_OFF;
         c_state_o <= c_group_on_i ? c_dec : REQ_OFF;
         f_state_o <= decode_state(f_st_q);
         d_cmd_o   <= pick_cmd(off_c, {1'b0, slp_lo_q[0]},
                               {act_hi_q[0], 1'b1}, sys_state_i);
         c_cmd_o   <= pick_cmd(off_c, {1'b0, slp_lo_q[1]},
                               {act_hi_q[1], 1'b1}, sys_state_i);
         f_cmd_o   <= pick_cmd(off_c, {1'b0, slp_lo_q[2]},
                               {act_hi_q[2], 1'b1}, sys_state_i);
         ln_cmd_o  <= pick_cmd(off_c, {1'b0, slp_lo_q[3]},
                               {act_hi_q[3], 1'b1}, sys_state_i);
      end
   end

endmodule : ldo_regulator_control_regs

// File: pkg/ldo_regs_consts.svh
// Offsets, field positions and reset values of the regulator register bank.
`ifndef LDO_REGS_CONSTS_SVH
`define LDO_REGS_CONSTS_SVH

`define CONTROL_SLAVE_ADDR_ONE   7'h48

`define OFS_LDO_B_STATE          8'h86
`define OFS_LDO_B_VOLTAGE        8'h87
`define OFS_LDO_D_TRANSITION_CMD 8'h89
`define OFS_LDO_D_STATE          8'h8a
`define OFS_LDO_D_VOLTAGE        8'h8b
`define OFS_LDO_C_TRANSITION_CMD 8'h8d
`define OFS_LDO_C_STATE          8'h8e
`define OFS_LDO_C_VOLTAGE        8'h8f
`define OFS_LDO_F_TRANSITION_CMD 8'h91
`define OFS_LDO_F_STATE          8'h92
`define OFS_LDO_F_VOLTAGE        8'h93
`define OFS_LOW_NOISE_TRANSITION_CMD 8'h95

`define STATE_RST                2'h0
`define OFF_CMD_RST              2'h0
`define SLEEP_CMD_LO_RST         1'h1
`define ACT_CMD_HI_RST           1'h0
`define RETAIN_RST               1'h0

`define POS_RETAIN               7
`define POS_VOLTAGE_SELECT_CODE_TOP             5
`define POS_OFF_CMD              4
`define POS_SLEEP_CMD            2
`define POS_ACT_CMD              0

`endif

// File: pkg/ldo_regs_pkg.sv
// Types shared by the regulator register bank.
package ldo_regs_pkg;

   typedef enum logic [1:0] {
      REQ_OFF   = 2'b00,
      REQ_ON    = 2'b01,
      REQ_SLEEP = 2'b11
   } ldo_state_e;

   typedef enum logic [1:0] {
      CMD_OFF      = 2'b00,
      CMD_AUTO     = 2'b01,
      CMD_RESERVED = 2'b10,
      CMD_ACTIVE   = 2'b11
   } ldo_cmd_e;

   typedef enum logic [1:0] {
      SYS_OFF    = 2'b00,
      SYS_SLEEP  = 2'b01,
      SYS_ACTIVE = 2'b10
   } sys_state_e;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_s;

endpackage : ldo_regs_pkg

// File: hw/ldo_voltage_reg.sv
// One voltage register with warm-reset retention of its selection code.
`timescale 1ns/1ps
`include "ldo_regs_consts.svh"

module ldo_voltage_reg
   import ldo_regs_pkg::*;
#(
   parameter bit TOP_BIT_WRITABLE = 1'b1
) (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rstn_i,
   // Reload controls
   input  wire logic       load_default_i,
   input  wire logic       warm_rst_i,
   // Register access
   input  wire logic       wr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic [5:0] nvm_default_i,
   // Register contents
   output logic      [7:0] rdata_o,
   output logic      [5:0] voltage_select_code_o
);

   ////////////////////////////////////////////////////////////////////////
   logic       retain_q;
   logic [5:0] voltage_select_code_q;
   wire  [5:0] voltage_select_code_mask     = {TOP_BIT_WRITABLE, 5'h1f};
   wire  [5:0] nvm_masked    = nvm_default_i & voltage_select_code_mask;
   wire        reload        = load_default_i | (warm_rst_i & ~retain_q);

   // The retention bit lives in the backup domain: warm_rst_i leaves it, only rstn_i or a write of zero clears it.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         retain_q <= `RETAIN_RST;
      end else if (wr_i) begin
         retain_q <= wdata_i[`POS_RETAIN];
      end
   end

   // Warm reload takes precedence over a write in the same cycle.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         voltage_select_code_q <= 6'h00;
      end else if (reload) begin
         voltage_select_code_q <= nvm_masked;
      end else if (wr_i) begin
         voltage_select_code_q <= wdata_i[5:0] & voltage_select_code_mask;
      end
   end

   assign rdata_o               = {retain_q, 1'b0, voltage_select_code_q};
   assign voltage_select_code_o = voltage_select_code_q;

endmodule : ldo_voltage_reg

// File: verif/ldo_regs_sva.sv
// Checker with the port-level properties of the regulator register bank.
`timescale 1ns/1ps
`include "ldo_regs_consts.svh"

module ldo_regs_sva
   import ldo_regs_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rstn_i,
   input  wire logic       warm_rst_i,
   // Register port
   input  reg_req_s        req_i,
   input  wire logic [7:0] rdata_o,
   input  wire logic       rvalid_o,
   // Context and regulator controls
   input  sys_state_e      sys_state_i,
   input  wire logic       d_group_on_i,
   input  wire logic [5:0] b_nvm_voltage_select_code_i,
   input  ldo_state_e      b_state_o,
   input  ldo_state_e      d_state_o,
   input  ldo_cmd_e        f_cmd_o,
   input  ldo_cmd_e        ln_cmd_o,
   input  wire logic [5:0] b_voltage_select_code_o,
   input  wire logic [5:0] d_voltage_select_code_o
);
   logic [1:0] up_q;
   logic       ret_b_q;
   logic       up;
   logic       wr_bv;

   assign up    = (up_q == 2'h3);
   assign wr_bv = req_i.wr && (req_i.addr == `OFS_LDO_B_VOLTAGE);

   // Counts the edges of the internal reset release and mirrors retention.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         up_q    <= 2'h0;
         ret_b_q <= 1'b0;
      end else begin
         if (!up) up_q <= up_q + 2'h1;
         if (wr_bv) ret_b_q <= req_i.wdata[7];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   sequence s_wr_b_state;
      up && req_i.wr && (req_i.addr == `OFS_LDO_B_STATE);
   endsequence
   sequence s_rd_taken;
      up && req_i.rd;
   endsequence

   a_state_decode: assert property (s_wr_b_state |-> ##2
      b_state_o == {&$past(req_i.wdata[1:0], 2), $past(req_i.wdata[0], 2)})
      else $error("b state does not follow written field");
   a_group_gate: assert property (
      d_state_o != REQ_OFF |-> $past(d_group_on_i))
      else $error("d state applied without its group");
   a_off_cmd: assert property (
      up && sys_state_i == SYS_OFF |=> f_cmd_o == CMD_OFF)
      else $error("f command not off in off state");
   a_sleep_cmd_top: assert property (
      up && sys_state_i == SYS_SLEEP |=> f_cmd_o[1] == 1'b0)
      else $error("sleep command upper bit not zero");
   a_act_cmd_low: assert property (
      up && sys_state_i == SYS_ACTIVE |=> ln_cmd_o[0] == 1'b1)
      else $error("active command lower bit not one");
   a_warm_reload: assert property (
      up && warm_rst_i && !ret_b_q && !wr_bv |=> b_voltage_select_code_o == $past(b_nvm_voltage_select_code_i))
      else $error("b code not reloaded on warm reset");
   a_warm_keep: assert property (
      up && warm_rst_i && ret_b_q && !wr_bv |=> $stable(b_voltage_select_code_o))
      else $error("b code lost on warm reset");
   a_voltage_select_code_top_zero: assert property (d_voltage_select_code_o[5] == 1'b0)
      else $error("d code bit five not zero");
   a_read_answer: assert property (s_rd_taken |=> rvalid_o)
      else $error("read not answered next cycle");
   a_unmapped_zero: assert property (
      s_rd_taken and (req_i.addr == 8'h85) |=> rdata_o == 8'h00)
      else $error("unmapped read not zero");
endmodule : ldo_regs_sva

bind ldo_regulator_control_regs ldo_regs_sva i_ldo_regs_sva (
   .clk_i(clk_i), .rstn_i(rstn_i), .warm_rst_i(warm_rst_i), .req_i(req_i),
   .rdata_o(rdata_o), .rvalid_o(rvalid_o), .sys_state_i(sys_state_i),
   .d_group_on_i(d_group_on_i), .b_nvm_voltage_select_code_i(b_nvm_voltage_select_code_i),
   .b_state_o(b_state_o), .d_state_o(d_state_o), .f_cmd_o(f_cmd_o),
   .ln_cmd_o(ln_cmd_o), .b_voltage_select_code_o(b_voltage_select_code_o), .d_voltage_select_code_o(d_voltage_select_code_o));

// File: verif/tb_top.sv
// Self-checking bench for the regulator register bank.
`timescale 1ns/1ps
`include "ldo_regs_consts.svh"

module tb_top
   import ldo_regs_pkg::*;
;
   logic       clk_i = 1'b0;
   logic       rstn_i = 1'b0;
   logic       warm_rst_i = 1'b0;
   reg_req_s   req_i = '0;
   sys_state_e sys_state_i = SYS_OFF;
   logic       d_group_on_i = 1'b0;
   logic       c_group_on_i = 1'b0;
   logic [5:0] nvm [4] = '{6'h2a, 6'h35, 6'h21, 6'h3f};
   logic [7:0] rdata_o;
   logic       rvalid_o;
   ldo_state_e st [4];
   ldo_cmd_e   cmd [4];
   logic [5:0] voltage_select_code [4];
   logic [7:0] w;
   int         fail_count = 0;
   int         samples_checked = 0;
   logic [7:0] w_list [3] = '{8'hff, 8'h5a, 8'h00};
   logic [7:0] ra [13] = '{8'h85, 8'h86, 8'h87, 8'h89, 8'h8a, 8'h8b, 8'h8d,
                           8'h8e, 8'h8f, 8'h91, 8'h92, 8'h93, 8'h95};
   logic [7:0] rv [13] = '{8'h00, 8'h00, 8'h2a, 8'h05, 8'h00, 8'h15, 8'h05,
                           8'h00, 8'h01, 8'h05, 8'h00, 8'h1f, 8'h05};

   always #20 clk_i = ~clk_i;

   ldo_regulator_control_regs i_ldo_regulator_control_regs (
      .clk_i(clk_i), .rstn_i(rstn_i), .warm_rst_i(warm_rst_i), .req_i(req_i),
      .rdata_o(rdata_o), .rvalid_o(rvalid_o), .sys_state_i(sys_state_i),
      .d_group_on_i(d_group_on_i), .c_group_on_i(c_group_on_i),
      .b_nvm_voltage_select_code_i(nvm[0]), .d_nvm_voltage_select_code_i(nvm[1]), .c_nvm_voltage_select_code_i(nvm[2]),
      .f_nvm_voltage_select_code_i(nvm[3]), .b_state_o(st[0]), .d_state_o(st[1]),
      .c_state_o(st[2]), .f_state_o(st[3]), .d_cmd_o(cmd[0]),
      .c_cmd_o(cmd[1]), .f_cmd_o(cmd[2]), .ln_cmd_o(cmd[3]),
      .b_voltage_select_code_o(voltage_select_code[0]), .d_voltage_select_code_o(voltage_select_code[1]), .c_voltage_select_code_o(voltage_select_code[2]),
      .f_voltage_select_code_o(voltage_select_code[3]));

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [7:0] exp,
                        input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      req_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_i);
      req_i.wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_i);
      req_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk_i);
      req_i.rd <= 1'b0;
      #1;
      check("rvalid", 8'h01, {7'h00, rvalid_o});
      check($sformatf("reg %h", a), exp, rdata_o);
   endtask : rd

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : tick

   // Expected readback of a written byte, by register kind.
   function automatic logic [7:0] mask(input logic [7:0] a,
                                       input logic [7:0] d);
      case (a)
         8'h86, 8'h8a, 8'h8e, 8'h92: mask = {6'h00, d[1:0]};
         8'h87: mask = {d[7], 1'b0, d[5:0]};
         8'h8b, 8'h8f, 8'h93: mask = {d[7], 2'b00, d[4:0]};
         8'h89, 8'h8d, 8'h91, 8'h95: mask = {5'h00, d[2:1], 1'b1};
         default: mask = 8'h00;
      endcase
   endfunction : mask

   task automatic give_verdict;
      $display("Checks %0d errors %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : give_verdict

   ////////////////////////////////////////////////////////////////////////
   // The tests need well under a thousand cycles.
   initial begin
      repeat (5000) @(posedge clk_i);
      fail_count++;
      give_verdict();
   end

   initial begin
      repeat (12) @(posedge clk_i);
      rstn_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      for (int i = 0; i < 13; i++) rd(ra[i], rv[i]);
      foreach (w_list[k]) begin
         w = w_list[k];
         for (int i = 0; i < 13; i++) begin
            wr(ra[i], w);
            rd(ra[i], mask(ra[i], w));
         end
      end
      for (int v = 0; v < 8; v++) begin
         d_group_on_i <= v[2];
         c_group_on_i <= ~v[2];
         wr(8'h86, v[7:0]);
         wr(8'h8a, v[7:0]);
         wr(8'h8e, v[7:0]);
         wr(8'h92, v[7:0]);
         tick(1);
         w = {6'h00, &v[1:0], v[0]};
         check("b state", w, {6'h00, st[0]});
         check("d state", v[2] ? w : 8'h00, {6'h00, st[1]});
         check("c state", v[2] ? 8'h00 : w, {6'h00, st[2]});
         check("f state", w, {6'h00, st[3]});
      end
      foreach (w_list[k]) begin
         w = w_list[k];
         wr(8'h89, w);
         wr(8'h8d, w);
         wr(8'h91, w);
         wr(8'h95, w);
         for (int s = 0; s < 4; s++) begin
            @(posedge clk_i);
            sys_state_i <= sys_state_e'(s[1:0]);
            tick(2);
            for (int r = 0; r < 4; r++) begin
               check("cmd", (s == 1) ? {7'h00, w[2]} : (s == 2) ?
                  {6'h00, w[1], 1'b1} : 8'h00, {6'h00, cmd[r]});
            end
         end
      end
      wr(8'h87, 8'h15);
      wr(8'h8b, 8'h8c);
      @(posedge clk_i);
      warm_rst_i <= 1'b1;
      @(posedge clk_i);
      warm_rst_i <= 1'b0;
      #1;
      check("b voltage_select_code", {2'b00, nvm[0]}, {2'b00, voltage_select_code[0]});
      check("d voltage_select_code", 8'h0c, {2'b00, voltage_select_code[1]});
      check("c voltage_select_code", 8'h01, {2'b00, voltage_select_code[2]});
      check("f voltage_select_code", 8'h1f, {2'b00, voltage_select_code[3]});
      rd(8'h87, 8'h2a);
      rd(8'h8b, 8'h8c);
      rd(8'h89, 8'h05);
      wr(8'h87, 8'h95);
      @(posedge clk_i);
      warm_rst_i <= 1'b1;
      @(posedge clk_i);
      warm_rst_i <= 1'b0;
      #1;
      check("b voltage_select_code kept", 8'h15, {2'b00, voltage_select_code[0]});
      rd(8'h87, 8'h95);
      give_verdict();
   end

endmodule : tb_top
